// >>> verilog/rxca_pkg.sv
// Shared constants and types for the receive clock mode and comma align block.
package rxca_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] RXCA_ADDR_STATUS = 4'h0;
  localparam logic [3:0] RXCA_ADDR_MASK = 4'h1;
  localparam logic [3:0] RXCA_ADDR_STATE = 4'h2;
  localparam logic [2:0] RXCA_STATUS_RST = 3'h0;
  localparam logic [2:0] RXCA_MASK_RST = 3'h0;
  localparam int RXCA_EV_COMMA = 0;
  localparam int RXCA_EV_REALIGN = 1;
  localparam int RXCA_EV_PRBS_ERR = 2;
  localparam int RXCA_ST_HOLD = 0;
  localparam int RXCA_ST_MODE_LO = 1;
  localparam int RXCA_ST_PRBS_PASS = 4;
  localparam int RXCA_ST_ALIGN_EN = 5;

  // ****************************************************************
  // Word framing
  // ****************************************************************
  localparam int RXCA_WORD_W = 10;
  localparam int RXCA_HALF_W = 5;
  localparam logic [6:0] RXCA_COMMA_PAT = 7'h1f;
  localparam logic [3:0] RXCA_COMMA_LAST_POS = 4'h6;
  localparam logic [3:0] RXCA_REALIGN_POS = 4'h7;
  localparam logic [3:0] RXCA_LAST_POS = 4'h9;
  localparam logic [3:0] RXCA_CLK_FALL_POS = 4'h5;
  localparam logic [3:0] RXCA_OUT_POS = 4'h5;
  localparam logic [3:0] RXCA_DDR_LO_POS = 4'h7;
  localparam logic [3:0] RXCA_DDR_HI_POS = 4'h2;
  localparam logic [3:0] RXCA_PRBS_CLEAN_MAX = 4'hf;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    RXCA_MODE_HALF = 3'b001,
    RXCA_MODE_FULL = 3'b010,
    RXCA_MODE_DDR = 3'b100
  } rxca_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxca_reg_req_t;

  typedef struct packed {
    logic rate_select;
    logic width_select;
    logic align_enable;
    logic prbs_enable;
  } rxca_pins_t;

endpackage : rxca_pkg

// >>> verilog/rxca_prbs_chk.sv
// Self-synchronising seven-bit pseudo-random sequence checker.
`timescale 1ns/1ps

module rxca_prbs_chk (
  input wire logic mclk, // Block clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic enable, // Checker enable.
  input wire logic bit_valid, // One received bit this cycle.
  input wire logic bit_in, // Received bit.
  output logic pass, // High while the sequence checks clean.
  output logic err // One-cycle pulse on a bit mismatch.
);
  import rxca_pkg::*;

  typedef struct packed {
    logic [6:0] hist;
    logic [3:0] clean;
    logic pass;
    logic err;
  } rxca_chk_st_t;

  rxca_chk_st_t st_q;
  rxca_chk_st_t st_d;
  logic predicted;

  always_comb begin
    st_d = st_q;
    predicted = st_q.hist[6] ^ st_q.hist[5];
    st_d.err = 1'b0;
    if (!enable) begin
      st_d.clean = 4'h0;
      st_d.pass = 1'b0;
    end else if (bit_valid) begin
      st_d.hist = {st_q.hist[5:0], bit_in};
      if (bit_in != predicted) begin
        st_d.clean = 4'h0;
        st_d.pass = 1'b0;
        st_d.err = 1'b1;
      end else if (st_q.clean != RXCA_PRBS_CLEAN_MAX) begin
        st_d.clean = st_q.clean + 4'h1;
      end else begin
        st_d.pass = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pass = st_q.pass;
  assign err = st_q.err;

  property p_err_drops_pass;
    @(posedge mclk) disable iff (!rst_n)
      err |-> !pass ##1 !pass;
  endproperty
  a_err_drops_pass: assert property (p_err_drops_pass) else $error("pass high after error");

endmodule : rxca_prbs_chk

// >>> verilog/rxca_top.sv
// Receive word clock generation, comma alignment and sync or test-pass output.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Half rate: each word valid at either rising edge.
// - Realignment moves word clocks to new word boundary.
// - Realignment only stretches clock phases, never shortens.
// - Half rate: clock a rises for words 1, 3.
// - Half rate: clock b rises for words 0, 2.
// - Full rate: clock a only, one word period.
// - Double rate: clock a only, data both edges.
// - Both selects low: half-rate clocks on both outputs.
// - Width low, rate high: full clock a, b low.
// - Width high: rate ignored, full clock a, b low.
// - Enabled alignment finds comma, realigns to word boundary.
// - Disabled alignment: raw words, no realignment.
// - Sync pulses on comma, only while alignment enabled.
// - Test mode: sync output shows checker pass.
// - Width low selects ten-bit, high five-bit interface.
// - Double rate: upper five outputs held low.
// - Test enable turns on generator and checker.
module rxca_top (
  input wire logic mclk, // Block clock, 25 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic serial_clk, // Recovered bit clock, asynchronous.
  input wire logic serial_data, // Recovered serial bit, asynchronous.
  input rxca_pkg::rxca_pins_t pins, // Mode pins, asynchronous.
  input rxca_pkg::rxca_reg_req_t reg_req, // Register request.
  output logic [7:0] rd_data, // Read data, one cycle after the strobe.
  output logic [9:0] rx_parallel_word, // Received word or half word.
  output logic rx_word_clock_a, // First receive word clock.
  output logic rx_word_clock_b, // Second receive word clock.
  output logic sync_pass, // Comma sync pulse or test pass.
  output logic prbs_gen_enable, // Enables the sequence generator.
  output logic irq // Level interrupt.
);
  import rxca_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdat_sync;
    logic sclk_prev;
    logic [1:0] rate_sync;
    logic [1:0] width_sync;
    logic [1:0] align_sync;
    logic [1:0] prbs_sync;
    rxca_mode_t mode;
    logic [3:0] bit_cnt;
    logic [1:0] word_cnt;
    logic [6:0] hist;
    logic [9:0] asm_word;
    logic asm_comma;
    logic [9:0] done_word;
    logic done_comma;
    logic [4:0] ddr_keep;
    logic [9:0] out_word;
    logic sync_out;
    logic clk_a;
    logic clk_b;
    logic want_a;
    logic hold;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] rdata;
  } rxca_st_t;

  rxca_st_t st_q;
  rxca_st_t st_d;
  logic bit_ev;
  logic bit_val;
  logic [6:0] hist_new;
  logic comma_now;
  logic realign;
  logic [3:0] next_cnt;
  logic want_a;
  logic want_b;
  logic [9:0] asm_new;
  logic [2:0] events;
  logic [7:0] state_word;
  logic prbs_pass;
  logic prbs_err;
  logic align_en;
  logic half_mode;

  assign bit_ev = st_q.sclk_sync[1] & ~st_q.sclk_prev;
  assign bit_val = st_q.sdat_sync[1];
  assign align_en = st_q.align_sync[1];
  assign half_mode = (st_q.mode == RXCA_MODE_HALF);

  rxca_prbs_chk u_prbs_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(st_q.prbs_sync[1]),
    .bit_valid(bit_ev),
    .bit_in(bit_val),
    .pass(prbs_pass),
    .err(prbs_err)
  );

  always_comb begin
    state_word = 8'h00;
    state_word[RXCA_ST_HOLD] = st_q.hold;
    state_word[RXCA_ST_MODE_LO +: 3] = st_q.mode;
    state_word[RXCA_ST_PRBS_PASS] = prbs_pass;
    state_word[RXCA_ST_ALIGN_EN] = align_en;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    hist_new = {st_q.hist[5:0], bit_val};
    comma_now = bit_ev && (hist_new == RXCA_COMMA_PAT) && align_en;
    realign = comma_now && (st_q.bit_cnt != RXCA_COMMA_LAST_POS);
    asm_new = st_q.asm_word;
    asm_new[st_q.bit_cnt] = bit_val;
    next_cnt = st_q.bit_cnt;
    want_a = st_q.want_a;
    want_b = 1'b0;
    events = 3'h0;

    // Pin synchronisers; the first stage feeds only the second.
    st_d.sclk_sync = {st_q.sclk_sync[0], serial_clk};
    st_d.sdat_sync = {st_q.sdat_sync[0], serial_data};
    st_d.sclk_prev = st_q.sclk_sync[1];
    st_d.rate_sync = {st_q.rate_sync[0], pins.rate_select};
    st_d.width_sync = {st_q.width_sync[0], pins.width_select};
    st_d.align_sync = {st_q.align_sync[0], pins.align_enable};
    st_d.prbs_sync = {st_q.prbs_sync[0], pins.prbs_enable};

    if (st_q.width_sync[1]) begin
      st_d.mode = RXCA_MODE_DDR;
    end else if (st_q.rate_sync[1]) begin
      st_d.mode = RXCA_MODE_FULL;
    end else begin
      st_d.mode = RXCA_MODE_HALF;
    end

    if (bit_ev) begin
      st_d.hist = hist_new;
      if (realign) begin
        // Comma bits become positions 0 to 6 of the new word.
        for (int i = 0; i < 7; i++) begin
          asm_new[i] = hist_new[6 - i];
        end
        next_cnt = RXCA_REALIGN_POS;
        // The cut word takes a number, so the held clock level matches the parity at release.
        st_d.word_cnt = st_q.word_cnt + 2'h1;
        st_d.asm_comma = 1'b1;
        events[RXCA_EV_REALIGN] = 1'b1;
      end else if (st_q.bit_cnt == RXCA_LAST_POS) begin
        st_d.done_word = asm_new;
        st_d.done_comma = st_q.asm_comma;
        st_d.asm_comma = 1'b0;
        st_d.word_cnt = st_q.word_cnt + 2'h1;
        next_cnt = 4'h0;
      end else begin
        if (comma_now) begin
          st_d.asm_comma = 1'b1;
        end
        next_cnt = st_q.bit_cnt + 4'h1;
      end
      if (comma_now) begin
        events[RXCA_EV_COMMA] = 1'b1;
      end
      st_d.asm_word = asm_new;
      st_d.bit_cnt = next_cnt;

      // Output words change mid-period so they stand across the clock edge.
      if (st_q.mode == RXCA_MODE_DDR) begin
        if (next_cnt == RXCA_DDR_LO_POS) begin
          st_d.out_word = {5'h00, st_q.done_word[4:0]};
          st_d.ddr_keep = st_q.done_word[9:5];
          st_d.sync_out = st_q.done_comma & align_en;
        end else if (next_cnt == RXCA_DDR_HI_POS) begin
          st_d.out_word = {5'h00, st_q.ddr_keep};
        end
      end else if (next_cnt == RXCA_OUT_POS) begin
        st_d.out_word = st_q.done_word;
        st_d.sync_out = st_q.done_comma & align_en;
      end

      // Desired clock levels in the new phase.
      if (half_mode) begin
        want_a = st_d.word_cnt[0];
      end else begin
        want_a = (next_cnt < RXCA_CLK_FALL_POS);
      end
      st_d.want_a = want_a;

      if (realign) begin
        st_d.hold = 1'b1;
      end else if (st_q.hold) begin
        // Release only at the start of a phase equal to the held level.
        if ((want_a != st_q.want_a) && (want_a == st_q.clk_a)) begin
          st_d.hold = 1'b0;
        end
      end else begin
        st_d.clk_a = want_a;
        st_d.clk_b = half_mode & ~want_a;
      end
    end

    if (!half_mode) begin
      st_d.clk_b = 1'b0;
    end
    if (st_q.mode == RXCA_MODE_DDR) begin
      st_d.out_word[9:5] = 5'h00;
    end
    if (!align_en) begin
      st_d.sync_out = 1'b0;
    end
    events[RXCA_EV_PRBS_ERR] = prbs_err;

    // Register slave; a new event wins over the read clear.
    st_d.rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        RXCA_ADDR_STATUS: begin
          st_d.rdata = {5'h00, st_q.status};
        end
        RXCA_ADDR_MASK: begin
          st_d.rdata = {5'h00, st_q.mask};
        end
        RXCA_ADDR_STATE: begin
          st_d.rdata = state_word;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
    if (reg_req.rd && (reg_req.addr == RXCA_ADDR_STATUS)) begin
      st_d.status = events;
    end else begin
      st_d.status = st_q.status | events;
    end
    if (reg_req.wr && (reg_req.addr == RXCA_ADDR_MASK)) begin
      st_d.mask = reg_req.wdata[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.mode <= RXCA_MODE_HALF;
      st_q.status <= RXCA_STATUS_RST;
      st_q.mask <= RXCA_MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data = st_q.rdata;
  assign rx_parallel_word = st_q.out_word;
  assign rx_word_clock_a = st_q.clk_a;
  assign rx_word_clock_b = st_q.clk_b;
  assign sync_pass = st_q.prbs_sync[1] ? prbs_pass : st_q.sync_out;
  assign prbs_gen_enable = st_q.prbs_sync[1];
  assign irq = |(st_q.status & st_q.mask);

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [3:0] seg_bits_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seg_bits_q <= 4'hf;
    end else if (st_q.mode != st_d.mode) begin
      // A mode switch may cut one phase; the first toggle after it is not measured.
      seg_bits_q <= 4'hf;
    end else if (st_q.clk_a != st_d.clk_a) begin
      seg_bits_q <= 4'h0;
    end else if (bit_ev && (seg_bits_q != 4'hf)) begin
      seg_bits_q <= seg_bits_q + 4'h1;
    end
  end

  property p_no_short_phase;
    @(posedge mclk) disable iff (!rst_n)
      (st_q.clk_a != st_d.clk_a) && (seg_bits_q != 4'hf) |-> seg_bits_q >= 4'h4;
  endproperty
  a_no_short_phase: assert property (p_no_short_phase) else $error("short clock phase");

  property p_half_antiphase;
    @(posedge mclk) disable iff (!rst_n)
      half_mode && $stable(st_q.mode) && !st_q.hold && $changed(st_q.clk_a)
        |-> st_q.clk_b == !st_q.clk_a;
  endproperty
  a_half_antiphase: assert property (p_half_antiphase) else $error("clocks not antiphase");

  property p_b_low_not_half;
    @(posedge mclk) disable iff (!rst_n)
      !half_mode |=> !rx_word_clock_b;
  endproperty
  a_b_low_not_half: assert property (p_b_low_not_half) else $error("clock b active");

  property p_a_rise_odd;
    @(posedge mclk) disable iff (!rst_n)
      half_mode && $stable(st_q.mode) && $rose(st_q.clk_a) |-> st_q.word_cnt[0];
  endproperty
  a_a_rise_odd: assert property (p_a_rise_odd) else $error("clock a on even word");

  property p_b_rise_even;
    @(posedge mclk) disable iff (!rst_n)
      half_mode && $stable(st_q.mode) && $rose(st_q.clk_b) |-> !st_q.word_cnt[0];
  endproperty
  a_b_rise_even: assert property (p_b_rise_even) else $error("clock b on odd word");

  property p_ddr_upper_low;
    @(posedge mclk) disable iff (!rst_n)
      (st_q.mode == RXCA_MODE_DDR) && bit_ev ##1 (st_q.mode == RXCA_MODE_DDR)
        |-> rx_parallel_word[9:5] == 5'h00;
  endproperty
  a_ddr_upper_low: assert property (p_ddr_upper_low) else $error("upper bits driven");

  property p_realign_pos;
    @(posedge mclk) disable iff (!rst_n)
      realign |=> (st_q.bit_cnt == RXCA_REALIGN_POS) && st_q.hold;
  endproperty
  a_realign_pos: assert property (p_realign_pos) else $error("realign position wrong");

  property p_no_realign_disabled;
    @(posedge mclk) disable iff (!rst_n)
      !align_en |-> !realign ##1 !st_q.status[RXCA_EV_REALIGN] || $past(st_q.status[1]);
  endproperty
  a_no_realign_disabled: assert property (p_no_realign_disabled) else $error("realign off");

  property p_sync_needs_enable;
    @(posedge mclk) disable iff (!rst_n)
      !align_en && !st_q.prbs_sync[1] |=> !sync_pass || $past(st_q.prbs_sync[1], 1) || align_en;
  endproperty
  a_sync_needs_enable: assert property (p_sync_needs_enable) else $error("sync while off");

  property p_test_pass;
    @(posedge mclk) disable iff (!rst_n)
      st_q.prbs_sync[1] && prbs_err |=> !sync_pass;
  endproperty
  a_test_pass: assert property (p_test_pass) else $error("pass after error");

  c_realign: cover property (@(posedge mclk) disable iff (!rst_n) realign);
  c_half_a_rise: cover property (@(posedge mclk) disable iff (!rst_n)
    half_mode && $rose(st_q.clk_a));
  c_sync_pulse: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_q.sync_out));
  c_ddr_words: cover property (@(posedge mclk) disable iff (!rst_n)
    (st_q.mode == RXCA_MODE_DDR) && $rose(st_q.clk_a));

endmodule : rxca_top

// >>> verification/rxca_mac_model.sv
// Protocol-side model that captures received words on the word clocks.
`timescale 1ns/1ps

module rxca_mac_model (
  input wire logic mclk, // Block clock.
  input wire logic [9:0] rx_parallel_word, // Received data.
  input wire logic rx_word_clock_a, // First word clock.
  input wire logic rx_word_clock_b, // Second word clock.
  input wire logic sync_pass, // Sync indicator.
  input wire logic check_en, // Enables the clock checks.
  input wire logic [2:0] mode, // Expected mode, one-hot.
  output int errs, // Faults seen.
  output int checks // Checks made.
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  logic seen = 1'b0;
  logic [4:0] lo_q = 5'h00;
  logic sy_q = 1'b0;
  int run = 0;
  logic [9:0] q_word[$];
  logic q_b[$];
  logic q_sync[$];

  initial begin
    errs = 0;
    checks = 0;
  end

  task automatic fault(input string what);
    errs++;
    $display("mismatch at %0t: %s", $time, what);
  endtask : fault

  // ****
  // Clock checks and word capture
  // ****
  always @(posedge mclk) begin
    a_q <= rx_word_clock_a;
    b_q <= rx_word_clock_b;
    run <= (rx_word_clock_a != a_q) ? 1 : run + 1;
    seen <= check_en && (seen || rx_word_clock_a != a_q);
    if (check_en) begin
      checks++;
      if (seen && rx_word_clock_a != a_q && run < (mode[0] ? 78 : 38)) fault("short phase");
      if (mode[0] && rx_word_clock_b !== ~rx_word_clock_a) fault("b not antiphase");
      if (!mode[0] && rx_word_clock_b !== 1'b0) fault("b not low");
      if (mode[2] && rx_parallel_word[9:5] !== 5'h00) fault("upper half driven");
    end
    if (mode[2]) begin
      if (rx_word_clock_a && !a_q) begin
        lo_q <= rx_parallel_word[4:0];
        sy_q <= sync_pass;
      end
      if (!rx_word_clock_a && a_q) begin
        q_word.push_back({rx_parallel_word[4:0], lo_q});
        q_b.push_back(1'b0);
        q_sync.push_back(sy_q);
      end
    end else begin
      if ((rx_word_clock_a && !a_q) || (rx_word_clock_b && !b_q)) begin
        q_word.push_back(rx_parallel_word);
        q_b.push_back(rx_word_clock_b);
        q_sync.push_back(sync_pass);
      end
    end
  end
endmodule : rxca_mac_model

// >>> verification/rxca_top_tb_top.sv
// Self-checking bench for the receive clock mode and comma align block.
`timescale 1ns/1ps

module rxca_top_tb_top;
  import rxca_pkg::*;
  localparam logic [9:0] COMMA_WORD = 10'h17c;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic serial_clk = 1'b0;
  logic serial_data = 1'b0;
  rxca_pins_t pins = '0;
  rxca_reg_req_t reg_req = '0;
  logic [7:0] rd_data;
  logic [9:0] rx_parallel_word;
  logic rx_word_clock_a, rx_word_clock_b, sync_pass, prbs_gen_enable, irq;
  logic check_en = 1'b0;
  logic [2:0] mode = 3'b001;
  int mac_errs, mac_checks;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic bitq[$];
  logic [9:0] qw[$];
  logic qb[$], qs[$];
  logic [7:0] rdv;
  logic [6:0] ph;

  initial begin
    forever #20 mclk = ~mclk;
  end

  rxca_top rxca_top_inst (.mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .pins(pins), .reg_req(reg_req), .rd_data(rd_data),
    .rx_parallel_word(rx_parallel_word), .rx_word_clock_a(rx_word_clock_a),
    .rx_word_clock_b(rx_word_clock_b), .sync_pass(sync_pass),
    .prbs_gen_enable(prbs_gen_enable), .irq(irq));

  rxca_mac_model rxca_mac_model_inst (.mclk(mclk), .rx_parallel_word(rx_parallel_word),
    .rx_word_clock_a(rx_word_clock_a), .rx_word_clock_b(rx_word_clock_b),
    .sync_pass(sync_pass), .check_en(check_en), .mode(mode), .errs(mac_errs),
    .checks(mac_checks));

  // ****
  // Helpers
  // ****
  task automatic complete_run();
    num_errors += mac_errs;
    check_count += mac_checks;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : expect_eq

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] e,
                        input string what);
    @(posedge mclk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    #1 rdv = rd_data;
    expect_eq({8'h00, rdv & mask}, {8'h00, e}, what);
  endtask : rd_chk

  function automatic logic [2:0] mode_of(input logic r, input logic w);
    return w ? 3'b100 : (r ? 3'b010 : 3'b001);
  endfunction : mode_of

  task automatic filler(input int n);
    for (int j = 0; j < n; j++) bitq.push_back(j[0]);
  endtask : filler

  task automatic push_word(input logic [9:0] w);
    for (int j = 0; j < 10; j++) bitq.push_back(w[j]);
  endtask : push_word

  // The link clock runs only while bits are sent; data changes on its fall.
  task automatic send_bits();
    @(posedge mclk);
    while (bitq.size() > 0) begin
      serial_data <= bitq.pop_front();
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask : send_bits

  task automatic set_mode(input logic r, input logic w, input logic al, input logic pr);
    @(posedge mclk);
    check_en <= 1'b0;
    pins <= '{rate_select: r, width_select: w, align_enable: al, prbs_enable: pr};
    mode <= mode_of(r, w);
    filler(40);
    send_bits();
    rd_chk(RXCA_ADDR_STATE, 8'h2e, {2'b00, al, 1'b0, mode_of(r, w), 1'b0}, "mode");
    rd_chk(RXCA_ADDR_STATUS, 8'h03, 8'h00, "status clear");
    check_en <= 1'b1;
  endtask : set_mode

  task automatic check_seq(input int at, input logic [9:0] exp[$]);
    expect_eq(16'(qs[at]), 16'h1, "sync with comma");
    for (int j = 0; j < exp.size(); j++) begin
      expect_eq({5'h00, qs[at + 1 + j], qw[at + 1 + j]}, 16'(exp[j]), "word");
      if (mode[0] && j > 0) expect_eq(16'(qb[at + 1 + j] ^ qb[at + j]), 16'h1, "alt");
    end
  endtask : check_seq

  // Two commas, the second off the word grid, so the second forces a realignment.
  task automatic run_words(input int n, input logic al);
    int i1;
    int i2;
    int syncs;
    logic [9:0] w;
    logic [9:0] da[$];
    logic [9:0] db[$];
    i1 = -1;
    i2 = -1;
    syncs = 0;
    rxca_mac_model_inst.q_word.delete();
    rxca_mac_model_inst.q_b.delete();
    rxca_mac_model_inst.q_sync.delete();
    filler(3);
    push_word(COMMA_WORD);
    for (int j = 0; j < 3 + n; j++) begin
      if (j == 3) begin
        filler(11 + $urandom % 9);
        push_word(COMMA_WORD);
      end
      w = 10'($urandom) & 10'h2db;
      push_word(w);
      if (j < 3) da.push_back(w);
      else db.push_back(w);
    end
    filler(30);
    send_bits();
    qw = rxca_mac_model_inst.q_word;
    qb = rxca_mac_model_inst.q_b;
    qs = rxca_mac_model_inst.q_sync;
    for (int j = 0; j < qw.size(); j++) begin
      syncs += qs[j];
      if (qw[j] === COMMA_WORD && i1 < 0) i1 = j;
      else if (qw[j] === COMMA_WORD) i2 = j;
    end
    if (al) begin
      expect_eq(16'(i1 >= 0 && i2 > i1), 16'h1, "two commas");
      check_seq(i1, da);
      check_seq(i2, db);
      expect_eq(16'(irq), 16'h0, "irq masked");
      reg_wr(RXCA_ADDR_MASK, 8'h02);
      repeat (3) @(posedge mclk);
      expect_eq(16'(irq), 16'h1, "irq raised");
      rd_chk(RXCA_ADDR_STATUS, 8'hff, 8'h03, "events");
      repeat (3) @(posedge mclk);
      expect_eq(16'(irq), 16'h0, "irq cleared");
      reg_wr(RXCA_ADDR_MASK, 8'h00);
    end else begin
      expect_eq(16'(syncs), 16'h0, "sync while disabled");
      rd_chk(RXCA_ADDR_STATUS, 8'hff, 8'h00, "no realign");
    end
  endtask : run_words

  task automatic prbs_bits(input int n, input logic flip);
    logic b;
    for (int j = 0; j < n; j++) begin
      b = ph[6] ^ ph[5];
      ph = {ph[5:0], b};
      bitq.push_back(b ^ (flip && j == 0));
    end
    send_bits();
  endtask : prbs_bits

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(92));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(RXCA_ADDR_STATUS, 8'hff, RXCA_STATUS_RST, "status reset");
    rd_chk(RXCA_ADDR_MASK, 8'hff, RXCA_MASK_RST, "mask reset");
    rd_chk(RXCA_ADDR_STATE, 8'hff, 8'h02, "state reset");
    rd_chk(4'hf, 8'hff, 8'h00, "unmapped");
    reg_wr(4'h7, 8'hff);
    reg_wr(RXCA_ADDR_STATUS, 8'hff);
    rd_chk(RXCA_ADDR_STATUS, 8'hff, 8'h00, "status read only");
    reg_wr(RXCA_ADDR_MASK, 8'hff);
    rd_chk(RXCA_ADDR_MASK, 8'hff, 8'h07, "mask width");
    reg_wr(RXCA_ADDR_MASK, 8'h00);
    for (int i = 0; i < 4; i++) begin
      set_mode(i[0], i[1], 1'b1, 1'b0);
      run_words(6 + $urandom % 4, 1'b1);
    end
    set_mode(1'b1, 1'b0, 1'b0, 1'b0);
    run_words(6, 1'b0);
    set_mode(1'b1, 1'b0, 1'b0, 1'b1);
    expect_eq(16'(prbs_gen_enable), 16'h1, "generator on");
    ph = 7'($urandom) | 7'h01;
    prbs_bits(40, 1'b0);
    expect_eq(16'(sync_pass), 16'h1, "test pass");
    prbs_bits(4, 1'b1);
    expect_eq(16'(sync_pass), 16'h0, "test fail");
    rd_chk(RXCA_ADDR_STATUS, 8'h04, 8'h04, "bit error event");
    complete_run();
  end
endmodule : rxca_top_tb_top
